// file: ddrodt_pkg.sv
`default_nettype none
package ddrodt_pkg;
  localparam int CNT_W = 10;
  // Clock period and default latencies
  localparam int TCK_PS = 8000;
  localparam int CWL_DEF = 5;
  localparam int AL_DEF = 0;
  // Power-down termination times in ps
  localparam int TAONPD_MIN_PS = 2000;
  localparam int TAONPD_MAX_PS = 8500;
  localparam int TAOFPD_MIN_PS = 2000;
  localparam int TAOFPD_MAX_PS = 8500;
  // Other delays in ps
  localparam int TRP_PS = 15000;
  localparam int TRFC_PS = 260000;
  localparam int TXS_PS = 270000;
  localparam int TXPDLL_PS = 24000;
  // Async delays: least time rounded up, at least one cycle
  localparam int AON_CYC = (TAONPD_MIN_PS + TCK_PS - 1) / TCK_PS;
  localparam int AOF_CYC = (TAOFPD_MIN_PS + TCK_PS - 1) / TCK_PS;
  // Longest async delay, rounded down, at least one cycle
  localparam int AMAX_RAW = TAONPD_MAX_PS > TAOFPD_MAX_PS ?
    TAONPD_MAX_PS / TCK_PS : TAOFPD_MAX_PS / TCK_PS;
  localparam int AMAX_CYC = AMAX_RAW < 1 ? 1 : AMAX_RAW;
  // Cycle counts
  localparam logic [CNT_W-1:0] TRP_CYC =
    CNT_W'((TRP_PS + TCK_PS - 1) / TCK_PS);
  localparam logic [CNT_W-1:0] TRFC_CYC =
    CNT_W'((TRFC_PS + TCK_PS - 1) / TCK_PS);
  localparam logic [CNT_W-1:0] TXS_CYC =
    CNT_W'((TXS_PS + TCK_PS - 1) / TCK_PS);
  localparam logic [CNT_W-1:0] TXPDLL_CYC =
    CNT_W'((TXPDLL_PS + TCK_PS - 1) / TCK_PS);
  localparam logic [CNT_W-1:0] TCPDED_CYC = 10'h001;
  localparam logic [CNT_W-1:0] ZQINIT_CYC = 10'h200;
  localparam logic [CNT_W-1:0] ZQOPER_CYC = 10'h100;
  localparam logic [CNT_W-1:0] ZQCS_CYC = 10'h040;
  // Commands on the link
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_PREA = 3'h1,
    CMD_REF = 3'h2,
    CMD_ZQCL = 3'h3,
    CMD_ZQCS = 3'h4
  } ddrodt_cmd_t;
  // Device calibration engine states
  typedef enum logic [1:0] {
    ZQ_IDLE = 2'h0,
    ZQ_RUN = 2'h1,
    ZQ_XFER = 2'h3
  } ddrodt_zq_t;
  // Controller sequencer states
  typedef enum logic [1:0] {
    C_IDLE = 2'h0,
    C_TRP = 2'h1,
    C_QUIET = 2'h3
  } ddrodt_cst_t;
endpackage
`default_nettype wire

// file: ddrodt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ddrodt_if;
  logic cke;
  logic odt;
  ddrodt_pkg::ddrodt_cmd_t cmd;
  logic rtt_on;
  logic rtt_async;
  logic zq_busy;
  modport ctl (
    input rtt_on, rtt_async, zq_busy,
    output cke, odt, cmd
  );
  modport dev (
    input cke, odt, cmd,
    output rtt_on, rtt_async, zq_busy
  );
endinterface
`default_nettype wire

// file: ddrodt_dev.sv
`timescale 1ns/1ps
`default_nettype none
module ddrodt_dev #(
  parameter int CWL = ddrodt_pkg::CWL_DEF,
  parameter int AL = ddrodt_pkg::AL_DEF,
  parameter int CODE_W = 6
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link from controller
  ddrodt_if.dev link,
  // Mode register 0 bit A12: DLL kept on in power-down
  input wire logic mr0_pd_dll_on,
  // Calibration comparator, from outside the clock domain
  input wire logic zq_cmp_hi,
  // Status toward the device core
  output logic odt_window,
  output logic zq_current_en,
  output logic cal_update,
  output logic [CODE_W-1:0] io_code
);
  localparam int ODTL = CWL + AL - 2;
  localparam int HIST = ODTL + ddrodt_pkg::AON_CYC + ddrodt_pkg::AOF_CYC;
  localparam int CW = ddrodt_pkg::CNT_W;
  localparam logic [CODE_W-1:0] CODE_MAX = {CODE_W{1'b1}};
  localparam logic [CODE_W-1:0] CODE_MID = {1'b1, {(CODE_W-1){1'b0}}};

  logic [HIST-1:0] odt_hist_q;
  logic cke_q;
  logic async_q;
  logic rtt_q;
  logic [CW-1:0] win_cnt_q;
  logic [CW-1:0] rfc_cnt_q;
  ddrodt_pkg::ddrodt_zq_t zq_st_q;
  logic [CW-1:0] zq_cnt_q;
  logic zq_init_done_q;
  logic zq_cur_q;
  logic zq_busy_q;
  logic cal_upd_q;
  logic [CODE_W-1:0] work_q;
  logic [CODE_W-1:0] code_q;
  logic cmp_s1_q;
  logic cmp_s2_q;
  logic win_act_q;

  // Mode and window decode
  wire frozen = ~mr0_pd_dll_on;
  wire cke_fall = cke_q & ~link.cke;
  wire cke_rise = ~cke_q & link.cke;
  wire win_idle = (win_cnt_q == '0);
  wire [CW-1:0] entry_len = (rfc_cnt_q > ddrodt_pkg::TCPDED_CYC) ?
    rfc_cnt_q : ddrodt_pkg::TCPDED_CYC;
  wire [CW-1:0] entry_win = (entry_len > win_cnt_q) ?
    entry_len : win_cnt_q;
  wire [CW-1:0] exit_win = (ddrodt_pkg::TXPDLL_CYC > win_cnt_q) ?
    ddrodt_pkg::TXPDLL_CYC : win_cnt_q;

  // Termination path selection
  wire sync_val = odt_hist_q[ODTL-1];
  wire async_on = odt_hist_q[ddrodt_pkg::AON_CYC-1];
  wire async_off = odt_hist_q[ddrodt_pkg::AOF_CYC-1];
  wire async_val = rtt_q ? async_off : async_on;
  wire rtt_d = async_q ? async_val : sync_val;

  // Calibration decode
  wire cmd_zql = (link.cmd == ddrodt_pkg::CMD_ZQCL);
  wire cmd_zqs = (link.cmd == ddrodt_pkg::CMD_ZQCS);
  wire zq_start = (zq_st_q == ddrodt_pkg::ZQ_IDLE) & (cmd_zql | cmd_zqs);
  wire [CW-1:0] zq_len = cmd_zqs ? ddrodt_pkg::ZQCS_CYC :
    zq_init_done_q ? ddrodt_pkg::ZQOPER_CYC :
    ddrodt_pkg::ZQINIT_CYC;
  wire [CW-1:0] zq_load = zq_len - CW'(2);
  wire work_up = cmp_s2_q & (work_q != CODE_MAX);
  wire work_dn = ~cmp_s2_q & (work_q != '0);

  // Link and user outputs
  assign link.rtt_on = rtt_q;
  assign link.rtt_async = async_q;
  assign link.zq_busy = zq_busy_q;
  assign odt_window = win_act_q;
  assign zq_current_en = zq_cur_q;
  assign cal_update = cal_upd_q;
  assign io_code = code_q;

  // Termination input history and clock enable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      odt_hist_q <= '0;
      cke_q <= 1'b1;
      rtt_q <= 1'b0;
    end else begin
      odt_hist_q <= {odt_hist_q[HIST-2:0], link.odt};
      cke_q <= link.cke;
      rtt_q <= rtt_d;
    end
  end

  // Refresh in progress tracker
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rfc_cnt_q <= '0;
    end else if (link.cmd == ddrodt_pkg::CMD_REF) begin
      rfc_cnt_q <= ddrodt_pkg::TRFC_CYC;
    end else if (rfc_cnt_q != '0) begin
      rfc_cnt_q <= rfc_cnt_q - CW'(1);
    end
  end

  // Transition windows; the entry window lasts the longer of TCPDED_CYC
  // and the refresh still in progress, and keeps the sync timing
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      win_cnt_q <= '0;
      win_act_q <= 1'b0;
    end else begin
      if (cke_fall && frozen) begin
        win_cnt_q <= entry_win;
      end else if (cke_rise && frozen) begin
        win_cnt_q <= exit_win;
      end else if (!win_idle) begin
        win_cnt_q <= win_cnt_q - CW'(1);
      end
      win_act_q <= ~win_idle | ((cke_fall | cke_rise) & frozen);
    end
  end

  // Sync or async mode; held through a window
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      async_q <= 1'b0;
    end else if (win_idle) begin
      async_q <= ~cke_q & frozen;
    end
  end

  // Comparator synchroniser
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= zq_cmp_hi;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // Calibration engine state machine
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      zq_st_q <= ddrodt_pkg::ZQ_IDLE;
      zq_cnt_q <= '0;
      zq_init_done_q <= 1'b0;
      zq_cur_q <= 1'b0;
      zq_busy_q <= 1'b0;
      cal_upd_q <= 1'b0;
    end else begin
      cal_upd_q <= 1'b0;
      case (zq_st_q)
        ddrodt_pkg::ZQ_IDLE: begin
          if (zq_start) begin
            zq_st_q <= ddrodt_pkg::ZQ_RUN;
            zq_cnt_q <= zq_load;
            zq_cur_q <= 1'b1;
            zq_busy_q <= 1'b1;
            if (cmd_zql) begin
              zq_init_done_q <= 1'b1;
            end
          end
        end
        ddrodt_pkg::ZQ_RUN: begin
          if (zq_cnt_q == '0) begin
            zq_st_q <= ddrodt_pkg::ZQ_XFER;
            zq_cur_q <= 1'b0;
          end else begin
            zq_cnt_q <= zq_cnt_q - CW'(1);
          end
        end
        ddrodt_pkg::ZQ_XFER: begin
          zq_st_q <= ddrodt_pkg::ZQ_IDLE;
          zq_busy_q <= 1'b0;
          cal_upd_q <= 1'b1;
        end
        default: begin
          zq_st_q <= ddrodt_pkg::ZQ_IDLE;
          zq_cur_q <= 1'b0;
          zq_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Code search while running, transfer to I/O at the end; no
  // calibration starts without a command, also after self-refresh
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      work_q <= CODE_MID;
      code_q <= CODE_MID;
    end else begin
      if (zq_st_q == ddrodt_pkg::ZQ_RUN) begin
        if (work_up) begin
          work_q <= work_q + CODE_W'(1);
        end else if (work_dn) begin
          work_q <= work_q - CODE_W'(1);
        end
      end
      if (zq_st_q == ddrodt_pkg::ZQ_XFER) begin
        code_q <= work_q;
      end
    end
  end
endmodule
`default_nettype wire

// file: ddrodt_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module ddrodt_ctl #(
  parameter int CWL = ddrodt_pkg::CWL_DEF,
  parameter int AL = ddrodt_pkg::AL_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link to device
  ddrodt_if.ctl link,
  // User requests
  input wire logic cke_req,
  input wire logic odt_req,
  input wire logic ref_req,
  input wire logic zql_req,
  input wire logic zqs_req,
  input wire logic sr_exit,
  input wire logic peer_zq_busy,
  // User status
  output logic zq_active,
  output logic zq_done,
  output logic odt_settled
);
  localparam int CW = ddrodt_pkg::CNT_W;
  localparam int ODTL = CWL + AL - 2;
  localparam int SYNC_MAX = ODTL + 1;
  localparam logic [CW-1:0] SETTLE_CYC = CW'((SYNC_MAX >
    ddrodt_pkg::AMAX_CYC) ? SYNC_MAX : ddrodt_pkg::AMAX_CYC);

  ddrodt_pkg::ddrodt_cst_t st_q;
  ddrodt_pkg::ddrodt_cmd_t cmd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] hold_q;
  logic [CW-1:0] settle_q;
  logic pend_l_q;
  logic pend_s_q;
  logic pend_r_q;
  logic long_q;
  logic init_done_q;
  logic cke_q;
  logic odt_q;
  logic act_q;
  logic done_q;
  logic settled_q;

  // Sequencer decode
  wire idle = (st_q == ddrodt_pkg::C_IDLE);
  wire do_ref = idle & pend_r_q & cke_q & ~act_q;
  wire do_zq = idle & ~do_ref & (pend_l_q | pend_s_q) & cke_q &
    (hold_q == '0) & ~peer_zq_busy & ~link.zq_busy;
  wire issue_l = (st_q == ddrodt_pkg::C_TRP) & (cnt_q == '0) & long_q;
  wire issue = (st_q == ddrodt_pkg::C_TRP) & (cnt_q == '0);
  wire [CW-1:0] zq_len = ~long_q ? ddrodt_pkg::ZQCS_CYC :
    init_done_q ? ddrodt_pkg::ZQOPER_CYC :
    ddrodt_pkg::ZQINIT_CYC;
  wire quiet = ~idle;
  wire odt_next = quiet ? odt_q : odt_req;

  assign link.cmd = cmd_q;
  assign link.cke = cke_q;
  assign link.odt = odt_q;
  assign zq_active = act_q;
  assign zq_done = done_q;
  assign odt_settled = settled_q;

  // Pending requests; a new request wins over its clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend_l_q <= 1'b0;
      pend_s_q <= 1'b0;
      pend_r_q <= 1'b0;
    end else begin
      pend_l_q <= zql_req | (pend_l_q & ~(do_zq & pend_l_q));
      pend_s_q <= zqs_req | (pend_s_q & ~(do_zq & ~pend_l_q));
      pend_r_q <= ref_req | (pend_r_q & ~do_ref);
    end
  end

  // Hold-off after refresh and self-refresh exit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= '0;
    end else if (sr_exit) begin
      hold_q <= ddrodt_pkg::TXS_CYC;
    end else if (do_ref) begin
      hold_q <= ddrodt_pkg::TRFC_CYC;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - CW'(1);
    end
  end

  // Precharge, wait, calibrate, stay quiet
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ddrodt_pkg::C_IDLE;
      cmd_q <= ddrodt_pkg::CMD_NOP;
      cnt_q <= '0;
      long_q <= 1'b0;
      init_done_q <= 1'b0;
      act_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cmd_q <= ddrodt_pkg::CMD_NOP;
      done_q <= 1'b0;
      case (st_q)
        ddrodt_pkg::C_IDLE: begin
          if (do_ref) begin
            cmd_q <= ddrodt_pkg::CMD_REF;
          end else if (do_zq) begin
            cmd_q <= ddrodt_pkg::CMD_PREA;
            cnt_q <= ddrodt_pkg::TRP_CYC;
            long_q <= pend_l_q;
            act_q <= 1'b1;
            st_q <= ddrodt_pkg::C_TRP;
          end
        end
        ddrodt_pkg::C_TRP: begin
          if (issue) begin
            cmd_q <= issue_l ? ddrodt_pkg::CMD_ZQCL :
              ddrodt_pkg::CMD_ZQCS;
            cnt_q <= zq_len;
            init_done_q <= init_done_q | issue_l;
            st_q <= ddrodt_pkg::C_QUIET;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        ddrodt_pkg::C_QUIET: begin
          if (cnt_q == '0) begin
            st_q <= ddrodt_pkg::C_IDLE;
            act_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        default: begin
          st_q <= ddrodt_pkg::C_IDLE;
          act_q <= 1'b0;
        end
      endcase
    end
  end

  // Clock enable and termination pins, frozen while not idle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cke_q <= 1'b1;
      odt_q <= 1'b0;
    end else begin
      if (idle && !do_ref && !do_zq) begin
        cke_q <= cke_req;
      end
      odt_q <= odt_next;
    end
  end

  // Worst-case termination settle after each change
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      settle_q <= '0;
      settled_q <= 1'b1;
    end else if (odt_next != odt_q) begin
      settle_q <= SETTLE_CYC;
      settled_q <= 1'b0;
    end else if (settle_q != '0) begin
      settle_q <= settle_q - CW'(1);
      settled_q <= (settle_q == CW'(1));
    end
  end
endmodule
`default_nettype wire

// file: ddrodt_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ddrodt_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link signals
  input wire logic cke,
  input wire logic odt,
  input wire ddrodt_pkg::ddrodt_cmd_t cmd,
  input wire logic rtt_on,
  input wire logic rtt_async,
  input wire logic zq_busy
);
  logic [9:0] bcnt_q, exp_q, rcnt_q;
  logic zql_q;
  // Calibration start decode and expected length
  wire logic is_zq = cmd == ddrodt_pkg::CMD_ZQCL ||
    cmd == ddrodt_pkg::CMD_ZQCS;
  wire logic zq_go = is_zq && !zq_busy;
  wire logic [9:0] len_d = (cmd == ddrodt_pkg::CMD_ZQCS) ?
    ddrodt_pkg::ZQCS_CYC :
    (zql_q ? ddrodt_pkg::ZQOPER_CYC : ddrodt_pkg::ZQINIT_CYC);
  // Busy length, expected length, cycles since refresh
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bcnt_q <= 10'h000;
      exp_q <= 10'h000;
      rcnt_q <= 10'h3FF;
      zql_q <= 1'b0;
    end else begin
      bcnt_q <= zq_busy ? bcnt_q + 10'h001 : 10'h000;
      if (zq_go) exp_q <= len_d;
      if (zq_go && cmd == ddrodt_pkg::CMD_ZQCL) zql_q <= 1'b1;
      if (cmd == ddrodt_pkg::CMD_REF) rcnt_q <= 10'h000;
      else if (rcnt_q != 10'h3FF) rcnt_q <= rcnt_q + 10'h001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  zq_start_a: assert property (zq_go |=> zq_busy)
    else $error("calibration did not start");
  zq_len_a: assert property ($fell(zq_busy) |->
    bcnt_q == exp_q)
    else $error("calibration period length wrong");
  quiet_a: assert property (zq_busy |-> cmd == ddrodt_pkg::CMD_NOP)
    else $error("command issued during calibration");
  zq_prea_a: assert property (is_zq |->
    $past(cmd, 3) == ddrodt_pkg::CMD_PREA)
    else $error("calibration without precharge spacing");
  sync_on_a: assert property ($rose(odt) && cke && !rtt_async
    ##1 !rtt_async [*3] |=> rtt_on)
    else $error("sync termination on latency wrong");
  sync_off_a: assert property ($fell(odt) && cke && !rtt_async
    ##1 !rtt_async [*3] |=> !rtt_on)
    else $error("sync termination off latency wrong");
  async_on_a: assert property ($rose(odt) && rtt_async && !cke
    |=> ##1 rtt_on)
    else $error("async termination on late");
  async_off_a: assert property ($fell(odt) && rtt_async && !cke
    |=> ##1 !rtt_on)
    else $error("async termination off late");
  async_mode_a: assert property ($rose(rtt_async) |-> !cke &&
    rcnt_q >= ddrodt_pkg::TRFC_CYC - 10'h001)
    else $error("async mode entered too early");
  entry_win_a: assert property ($fell(cke) |->
    !rtt_async ##1 !rtt_async)
    else $error("entry window cut short");
  exit_win_a: assert property ($rose(cke) && rtt_async |->
    rtt_async [*3] ##[1:4] !rtt_async)
    else $error("exit window length wrong");
endmodule
`default_nettype wire

// file: dram_async_odt_and_zq_calibration_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dram_async_odt_and_zq_calibration_tb_top;
  logic mclk, resetn, cke_req, odt_req, ref_req, zql_req, zqs_req;
  logic sr_exit, peer_zq_busy, mr0_pd_dll_on, zq_cmp_hi;
  logic zq_active, zq_done, odt_settled, odt_window, zq_current_en;
  logic cal_update;
  logic [5:0] io_code;
  int fail_count, num_checks, cyc;
  // Link and both ends
  ddrodt_if link ();
  ddrodt_ctl i_ddrodt_ctl (.mclk(mclk), .resetn(resetn), .link(link),
    .cke_req(cke_req), .odt_req(odt_req), .ref_req(ref_req),
    .zql_req(zql_req), .zqs_req(zqs_req), .sr_exit(sr_exit),
    .peer_zq_busy(peer_zq_busy), .zq_active(zq_active),
    .zq_done(zq_done), .odt_settled(odt_settled));
  ddrodt_dev i_ddrodt_dev (.mclk(mclk), .resetn(resetn), .link(link),
    .mr0_pd_dll_on(mr0_pd_dll_on), .zq_cmp_hi(zq_cmp_hi),
    .odt_window(odt_window), .zq_current_en(zq_current_en),
    .cal_update(cal_update), .io_code(io_code));
  ddrodt_asserts i_ddrodt_asserts (.mclk(mclk), .resetn(resetn),
    .cke(link.cke), .odt(link.odt), .cmd(link.cmd), .rtt_on(link.rtt_on),
    .rtt_async(link.rtt_async), .zq_busy(link.zq_busy));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks %0d, errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(string name, logic [9:0] seen, logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One calibration: request, wait for command, time the period
  task automatic zq_cycle(logic lng, logic [9:0] len, int min_n);
    int n;
    int cal;
    n = 0;
    cal = 0;
    @(posedge mclk);
    sr_exit <= 1'b0;
    zql_req <= lng;
    zqs_req <= !lng;
    @(posedge mclk);
    zql_req <= 1'b0;
    zqs_req <= 1'b0;
    #1;
    while (link.cmd !== (lng ? ddrodt_pkg::CMD_ZQCL : ddrodt_pkg::CMD_ZQCS)
      && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("zq_wait", n >= min_n, 1'b1);
    n = 0;
    while (zq_done !== 1'b1 && n < 600) begin
      @(posedge mclk);
      #1;
      n++;
      cal += int'(cal_update === 1'b1);
    end
    check("zq_len", 10'(n), len + 10'h001);
    check("cal_pulses", 10'(cal), 10'h001);
    check("zq_current", zq_current_en, 1'b0);
    @(posedge mclk);
    #1;
    check("zq_active", zq_active, 1'b0);
  endtask
  // Termination change timed from link request to rtt_on
  task automatic odt_lat(logic v, int exp);
    int n;
    n = 0;
    @(posedge mclk);
    odt_req <= v;
    #1;
    while (link.odt !== v && n < 10) begin
      @(posedge mclk);
      #1;
      n++;
    end
    n = 0;
    while (link.rtt_on !== v && n < 10) begin
      @(posedge mclk);
      #1;
      n++;
    end
    // Counted from the launch edge; the device registers odt one later
    check("odt_latency", 10'(n), 10'(exp + 1));
    repeat (6) @(posedge mclk);
    #1;
    check("odt_settled", odt_settled, 1'b1);
  endtask
  // Power-down entry and exit with the DLL frozen or kept on
  task automatic power_down(logic frz);
    @(posedge mclk);
    mr0_pd_dll_on <= !frz;
    cke_req <= 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    check("async_entry", link.rtt_async, frz);
    if (frz) begin
      odt_lat(1'b1, ddrodt_pkg::AON_CYC);
      odt_lat(1'b0, ddrodt_pkg::AOF_CYC);
    end
    @(posedge mclk);
    cke_req <= 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    check("async_exit", link.rtt_async, 1'b0);
  endtask
  // Refresh just before power-down stretches the entry window
  task automatic ref_pd();
    int n;
    n = 0;
    @(posedge mclk);
    ref_req <= 1'b1;
    @(posedge mclk);
    ref_req <= 1'b0;
    #1;
    while (link.cmd !== ddrodt_pkg::CMD_REF && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    cke_req <= 1'b0;
    repeat (20) @(posedge mclk);
    #1;
    check("ref_hold", link.rtt_async, 1'b0);
    check("win_open", odt_window, 1'b1);
    repeat (25) @(posedge mclk);
    #1;
    check("ref_end", link.rtt_async, 1'b1);
    check("win_shut", odt_window, 1'b0);
    @(posedge mclk);
    cke_req <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask
  // Calibration right after self-refresh exit
  task automatic sr_zq();
    @(posedge mclk);
    sr_exit <= 1'b1;
    zq_cycle(1'b0, ddrodt_pkg::ZQCS_CYC, 32);
  endtask
  // Peer rank calibrating blocks ours
  task automatic peer_zq();
    @(posedge mclk);
    peer_zq_busy <= 1'b1;
    fork
      zq_cycle(1'b0, ddrodt_pkg::ZQCS_CYC, 40);
      begin
        repeat (42) @(posedge mclk);
        peer_zq_busy <= 1'b0;
      end
    join
  endtask
  // Main sequence
  initial begin
    resetn = 1'b0;
    cke_req = 1'b1;
    {odt_req, ref_req, zql_req, zqs_req, sr_exit} = 5'h00;
    {peer_zq_busy, mr0_pd_dll_on} = 2'h0;
    zq_cmp_hi = 1'b1;
    repeat (16) @(posedge mclk);
    #1;
    check("reset_code", io_code, 6'h20);
    check("reset_rtt", link.rtt_on, 1'b0);
    @(posedge mclk);
    resetn <= 1'b1;
    zq_cycle(1'b1, ddrodt_pkg::ZQINIT_CYC, 0);
    check("code_moved", io_code != 6'h20, 1'b1);
    zq_cycle(1'b1, ddrodt_pkg::ZQOPER_CYC, 0);
    zq_cycle(1'b0, ddrodt_pkg::ZQCS_CYC, 0);
    odt_lat(1'b1, ddrodt_pkg::CWL_DEF + ddrodt_pkg::AL_DEF - 2);
    odt_lat(1'b0, ddrodt_pkg::CWL_DEF + ddrodt_pkg::AL_DEF - 2);
    power_down(1'b0);
    power_down(1'b1);
    ref_pd();
    sr_zq();
    peer_zq();
    stop_test();
  end
endmodule
`default_nettype wire
